/* motion_cmd_decoder.sv */
// Purpose: decodes stop, move and parameter-write frames for six axes
// Assumes: frames pushed byte-wise over wishbone, memory holds parameters
// Notes:   replies land in the reply register with a one-cycle reply_o pulse
`timescale 1ns/1ps
module motion_cmd_decoder import motion_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [5:0]  axis_start_o,
	output logic      [5:0]  interp_o,
	output logic      [5:0]  pos_mode_o,
	output logic      [5:0]  dir_o,
	output logic             reply_o
);
	// ****************************************
	// frame and memory
	// ****************************************
	logic              push_c, clear_c, f_full, f_sum_ok;
	logic [3:0]        f_count;
	logic [7:0]        f_addr, f_ins, f_type, f_motor;
	logic [31:0]       f_value, mem_rd, mem_wd, tgt_c, diff_c;
	logic              mem_we;
	logic [MEM_AW-1:0] mem_addr;
	logic [5:0]        mv_mask;
	logic              req;

	frame_rx i_frame_rx (
		.clk_i (clk_i), .rst_i (rst_i), .push_i (push_c), .byte_i (wb_dat_i[7:0]), .clear_i (clear_c),
		.full_o (f_full), .count_o (f_count), .addr_o (f_addr), .ins_o (f_ins), .type_o (f_type),
		.motor_o (f_motor), .value_o (f_value), .sum_ok_o (f_sum_ok)
	);

	axis_mem i_axis_mem (
		.clk_i (clk_i), .we_i (mem_we), .addr_i (mem_addr), .wdata_i (mem_wd), .rdata_o (mem_rd)
	);

	// ****************************************
	// decode and execute
	// ****************************************
	state_t            state_r, state_nxt;
	logic [5:0]        mask_r, mask_nxt, all_r, all_nxt;
	logic [5:0]        mode_r, mode_nxt, dir_r, dir_nxt, interp_r, interp_nxt, start_r, start_nxt;
	logic [2:0]        cur_r, cur_nxt;
	logic [31:0]       act_r, act_nxt, dat_r, dat_nxt;
	logic [7:0]        rstat_r, rstat_nxt, rins_r, rins_nxt, dev_r, dev_nxt, rcode_c;
	logic              rvld_r, rvld_nxt, rpulse_r, rpulse_nxt, ack_r, ack_nxt, rdo_c;
	logic [MEM_AW-1:0] maddr_r, maddr_nxt;

	assign req     = wb_cyc_i && wb_stb_i && !ack_r;
	assign mv_mask = axis_mask(f_type, f_motor);
	// 32-bit adds and differences wrap on purpose
	assign tgt_c  = (f_type == STORED_POINT_TARGET) ? mem_rd :
	                (f_type == RELATIVE_TARGET) ? act_r + f_value : f_value;
	assign diff_c = tgt_c - act_r;

	always_comb begin
		state_nxt  = state_r;
		mask_nxt   = mask_r;
		all_nxt    = all_r;
		cur_nxt    = cur_r;
		act_nxt    = act_r;
		mode_nxt   = mode_r;
		dir_nxt    = dir_r;
		interp_nxt = interp_r;
		start_nxt  = '0;
		rstat_nxt  = rstat_r;
		rins_nxt   = rins_r;
		rvld_nxt   = rvld_r;
		rpulse_nxt = 1'b0;
		maddr_nxt  = maddr_r;
		dev_nxt    = dev_r;
		ack_nxt    = 1'b0;
		dat_nxt    = dat_r;
		push_c     = 1'b0;
		clear_c    = 1'b0;
		mem_we     = 1'b0;
		mem_addr   = maddr_r;
		mem_wd     = wb_dat_i;
		rdo_c      = 1'b0;
		rcode_c    = ST_OK;
		case (state_r)
			S_IDLE: begin
				if (f_full) begin
					state_nxt = S_CHECK;
				end else if (req) begin
					ack_nxt = 1'b1;
					dat_nxt = '0;
					case (wb_adr_i)
						OFS_FRAME: push_c = wb_we_i && wb_sel_i[0];
						OFS_REPLY: begin
							if (wb_we_i) begin
								rvld_nxt = 1'b0;
							end else begin
								dat_nxt = {8'h00, rins_r, 7'h00, rvld_r, rstat_r};
							end
						end
						OFS_MADDR: begin
							if (wb_we_i) begin
								maddr_nxt = wb_dat_i[MEM_AW-1:0];
							end else begin
								dat_nxt = 32'(maddr_r);
							end
						end
						OFS_MDATA: begin
							if (wb_we_i) begin
								mem_we = (wb_sel_i == SEL_ALL);
							end else begin
								ack_nxt   = 1'b0;
								state_nxt = S_MRD;
							end
						end
						OFS_STATUS: dat_nxt = {2'h0, interp_r, 4'h0, f_count, 2'h0, dir_r, 2'h0, mode_r};
						OFS_DEVADR: begin
							if (wb_we_i) begin
								dev_nxt = wb_dat_i[7:0];
							end else begin
								dat_nxt = 32'(dev_r);
							end
						end
						default: dat_nxt = '0;
					endcase
				end
			end
			S_MRD: begin
				dat_nxt   = mem_rd;
				ack_nxt   = 1'b1;
				state_nxt = S_IDLE;
			end
			S_CHECK: begin
				clear_c   = 1'b1;
				state_nxt = S_IDLE;
				rins_nxt  = f_ins;
				if (f_addr != dev_r) begin
					rdo_c = 1'b0;
				end else if (!f_sum_ok) begin
					rdo_c   = 1'b1;
					rcode_c = ST_BAD_SUM;
				end else begin
					case (f_ins)
						INS_STOP: begin
							if (f_motor < NUM_AXES) begin
								cur_nxt   = f_motor[2:0];
								state_nxt = S_STOP;
							end else begin
								rdo_c   = 1'b1;
								rcode_c = ST_BAD_ARG;
							end
						end
						INS_MOVE: begin
							if (f_type > STORED_POINT_TARGET || mv_mask == '0 ||
							    (f_type == STORED_POINT_TARGET && f_value > MAX_STORED_POINT_TARGET)) begin
								rdo_c   = 1'b1;
								rcode_c = ST_BAD_ARG;
							end else begin
								mask_nxt   = mv_mask;
								all_nxt    = mv_mask;
								interp_nxt = (interp_r & ~mv_mask) |
								             ((f_type == STORED_POINT_TARGET && !f_motor[SEP_BIT] &&
								               f_motor[INTERP_BIT]) ? mv_mask : 6'h00);
								state_nxt  = S_RDACT;
							end
						end
						INS_SETP: begin
							rdo_c = 1'b1;
							if (f_motor < NUM_AXES && f_type < NUM_PARAMS) begin
								mem_we   = 1'b1;
								mem_addr = param_addr(f_motor[2:0], f_type[2:0]);
								mem_wd   = f_value;
							end else begin
								rcode_c = ST_BAD_ARG;
							end
						end
						default: begin
							rdo_c   = 1'b1;
							rcode_c = ST_BAD_CMD;
						end
					endcase
				end
			end
			S_STOP: begin
				// dropping position mode aborts any move in flight
				mode_nxt[cur_r]   = 1'b0;
				interp_nxt[cur_r] = 1'b0;
				mem_we    = 1'b1;
				mem_addr  = param_addr(cur_r, PAR_TGT_SPEED);
				mem_wd    = '0;
				rdo_c     = 1'b1;
				state_nxt = S_IDLE;
			end
			S_RDACT: begin
				cur_nxt   = low_axis(mask_r);
				mem_addr  = param_addr(low_axis(mask_r), PAR_ACT_POS);
				state_nxt = S_RDCRD;
			end
			S_RDCRD: begin
				act_nxt   = mem_rd;
				// point contents are whatever the host stored there
				mem_addr  = stored_point_target_addr(f_value[4:0], cur_r);
				state_nxt = S_CALC;
			end
			S_CALC: begin
				mem_we          = 1'b1;
				mem_addr        = param_addr(cur_r, PAR_TGT_POS);
				mem_wd          = tgt_c;
				dir_nxt[cur_r]  = diff_c[31];
				mode_nxt[cur_r] = 1'b1;
				mask_nxt[cur_r] = 1'b0;
				if (mask_nxt == '0) begin
					// ramp and speed come from the axis parameters untouched
					start_nxt = all_r;
					rdo_c     = 1'b1;
					state_nxt = S_IDLE;
				end else begin
					state_nxt = S_RDACT;
				end
			end
			default: state_nxt = S_IDLE;
		endcase
		if (rdo_c) begin
			rstat_nxt  = rcode_c;
			rvld_nxt   = 1'b1;
			rpulse_nxt = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r  <= S_IDLE;
			mask_r   <= '0;
			all_r    <= '0;
			cur_r    <= '0;
			act_r    <= '0;
			mode_r   <= '0;
			dir_r    <= '0;
			interp_r <= '0;
			start_r  <= '0;
			rstat_r  <= '0;
			rins_r   <= '0;
			rvld_r   <= 1'b0;
			rpulse_r <= 1'b0;
			maddr_r  <= '0;
			dev_r    <= DEV_ADDR_RST;
			ack_r    <= 1'b0;
			dat_r    <= '0;
		end else begin
			state_r  <= state_nxt;
			mask_r   <= mask_nxt;
			all_r    <= all_nxt;
			cur_r    <= cur_nxt;
			act_r    <= act_nxt;
			mode_r   <= mode_nxt;
			dir_r    <= dir_nxt;
			interp_r <= interp_nxt;
			start_r  <= start_nxt;
			rstat_r  <= rstat_nxt;
			rins_r   <= rins_nxt;
			rvld_r   <= rvld_nxt;
			rpulse_r <= rpulse_nxt;
			maddr_r  <= maddr_nxt;
			dev_r    <= dev_nxt;
			ack_r    <= ack_nxt;
			dat_r    <= dat_nxt;
		end
	end

	assign wb_dat_o     = dat_r;
	assign wb_ack_o     = ack_r;
	assign axis_start_o = start_r;
	assign interp_o     = interp_r;
	assign pos_mode_o   = mode_r;
	assign dir_o        = dir_r;
	assign reply_o      = rpulse_r;

	// ****************************************
	// checks
	// ****************************************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence move_taken;
		state_r == S_CHECK && f_addr == dev_r && f_sum_ok && f_ins == INS_MOVE && state_nxt == S_RDACT;
	endsequence

	sequence move_done;
		rpulse_r && rstat_r == ST_OK && start_r != '0;
	endsequence

	move_reply_a: assert property (move_taken |-> ##[4:20] move_done) else $error("move reply late");
	stop_speed_a: assert property (state_r == S_STOP |-> mem_we && mem_wd == '0 &&
		mem_addr == param_addr(cur_r, PAR_TGT_SPEED)) else $error("stop speed write wrong");
	stop_mode_a: assert property (state_r == S_STOP |=> !pos_mode_o[$past(cur_r)] && reply_o)
		else $error("stop left position mode");
	tgt_write_a: assert property (state_r == S_CALC |-> mem_we &&
		mem_addr == param_addr(cur_r, PAR_TGT_POS)) else $error("target not written");
	rel_sum_a: assert property (state_r == S_CALC && f_type == RELATIVE_TARGET |->
		mem_wd == act_r + f_value) else $error("relative sum wrong");
	dir_wrap_a: assert property (state_r == S_CALC |=> dir_o[$past(cur_r)] == $past(diff_c[31]))
		else $error("direction wrong");
	interp_cap_a: assert property (move_taken |=> $countones(interp_r & all_r) <= MAX_INTERP)
		else $error("too many interp axes");
	sum_reject_a: assert property (state_r == S_CHECK && f_addr == dev_r && !f_sum_ok |=>
		reply_o && rstat_r == ST_BAD_SUM && mode_r == $past(mode_r)) else $error("bad sum accepted");
	start_pulse_a: assert property (axis_start_o != '0 |-> state_r == S_IDLE ##1 axis_start_o == '0)
		else $error("start not a pulse");
	ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule

/* motion_pkg.sv */
// Purpose: shared constants and types for the motion command decoder
// Assumes: 32-bit classic wishbone slave, byte offsets below
// Notes:   frame is nine bytes, value field most significant byte first
package motion_pkg;

	// ****************************************
	// bus map
	// ****************************************
	localparam logic [7:0] OFS_FRAME  = 8'h00;
	localparam logic [7:0] OFS_REPLY  = 8'h04;
	localparam logic [7:0] OFS_MADDR  = 8'h08;
	localparam logic [7:0] OFS_MDATA  = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_DEVADR = 8'h14;
	localparam logic [3:0] SEL_ALL    = 4'hf;

	// ****************************************
	// command frame
	// ****************************************
	localparam logic [3:0] FRAME_LEN    = 4'h9;
	localparam logic [3:0] SUM_LEN      = 4'h8;
	localparam int         FRM_ADDR_LSB = 64;
	localparam int         FRM_INS_LSB  = 56;
	localparam int         FRM_TYPE_LSB = 48;
	localparam int         FRM_MOTOR_LSB = 40;
	localparam int         FRM_VALUE_LSB = 8;
	localparam int         FRM_SUM_LSB  = 0;
	localparam logic [7:0] DEV_ADDR_RST = 8'h01;

	localparam logic [7:0] INS_STOP = 8'h03;
	localparam logic [7:0] INS_MOVE = 8'h04;
	localparam logic [7:0] INS_SETP = 8'h05;

	localparam logic [7:0] ABSOLUTE_TARGET    = 8'h00;
	localparam logic [7:0] RELATIVE_TARGET    = 8'h01;
	localparam logic [7:0] STORED_POINT_TARGET = 8'h02;
	localparam int         SEP_BIT    = 7;
	localparam int         INTERP_BIT = 6;
	localparam int         MAX_INTERP = 3;

	localparam logic [7:0] ST_OK      = 8'h64;
	localparam logic [7:0] ST_BAD_SUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_ARG = 8'h04;

	// ****************************************
	// axes and parameter storage
	// ****************************************
	localparam int          AXES       = 6;
	localparam logic [7:0]  NUM_AXES   = 8'h06;
	localparam logic [7:0]  NUM_PARAMS = 8'h08;
	localparam int          MEM_AW     = 9;
	localparam logic [2:0]  PAR_TGT_POS   = 3'h0;
	localparam logic [2:0]  PAR_ACT_POS   = 3'h1;
	localparam logic [2:0]  PAR_TGT_SPEED = 3'h2;
	localparam logic [8:0]  STORED_POINT_TARGET_BASE = 9'h100;
	localparam logic [31:0] MAX_STORED_POINT_TARGET  = 32'h00000014;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_CHECK = 3'b001,
		S_STOP  = 3'b010,
		S_RDACT = 3'b011,
		S_RDCRD = 3'b100,
		S_CALC  = 3'b101,
		S_MRD   = 3'b110
	} state_t;

	// ****************************************
	// address and axis decoding
	// ****************************************
	function automatic logic [MEM_AW-1:0] param_addr(input logic [2:0] ax, input logic [2:0] idx);
		return {3'h0, ax, idx};
	endfunction

	function automatic logic [MEM_AW-1:0] stored_point_target_addr(input logic [4:0] pt, input logic [2:0] ax);
		return STORED_POINT_TARGET_BASE | {1'b0, pt, ax};
	endfunction

	function automatic logic [2:0] low_axis(input logic [5:0] m);
		logic [2:0] r;
		r = '0;
		for (int i = AXES - 1; i >= 0; i--) begin
			if (m[i]) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [5:0] axis_mask(input logic [7:0] ty, input logic [7:0] mo);
		logic [5:0] m;
		int         n;
		m = '0;
		n = 0;
		if (ty == STORED_POINT_TARGET && mo[SEP_BIT]) begin
			m = mo[5:0];
		end else if (ty == STORED_POINT_TARGET && mo[INTERP_BIT]) begin
			for (int i = 0; i < AXES; i++) begin
				if (mo[i] && n < MAX_INTERP) begin
					m[i] = 1'b1;
					n++;
				end
			end
		end else if (mo < NUM_AXES) begin
			m[mo[2:0]] = 1'b1;
		end
		return m;
	endfunction

endpackage

/* axis_mem.sv */
// Purpose: axis parameter and stored point memory
// Assumes: one port, read data registered one cycle after the address
// Notes:   no reset on contents
`timescale 1ns/1ps
module axis_mem import motion_pkg::*; (
	input  wire logic              clk_i,
	input  wire logic              we_i,
	input  wire logic [MEM_AW-1:0] addr_i,
	input  wire logic [31:0]       wdata_i,
	output logic      [31:0]       rdata_o
);
	// plain sram: contents are lost at power down
	logic [31:0] mem_r [0:(1<<MEM_AW)-1];
	logic [31:0] rd_r;

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem_r[addr_i] <= wdata_i;
		end
		rd_r <= mem_r[addr_i];
	end

	assign rdata_o = rd_r;
endmodule

/* frame_rx.sv */
// Purpose: gathers nine frame bytes and keeps a running checksum
// Assumes: pushes only while the decoder is idle
// Notes:   extra bytes after a full frame are dropped until clear
`timescale 1ns/1ps
module frame_rx import motion_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        push_i,
	input  wire logic [7:0]  byte_i,
	input  wire logic        clear_i,
	output logic             full_o,
	output logic      [3:0]  count_o,
	output logic      [7:0]  addr_o,
	output logic      [7:0]  ins_o,
	output logic      [7:0]  type_o,
	output logic      [7:0]  motor_o,
	output logic      [31:0] value_o,
	output logic             sum_ok_o
);
	logic [71:0] frame_r, frame_nxt;
	logic [3:0]  cnt_r, cnt_nxt;
	logic [7:0]  sum_r, sum_nxt;

	always_comb begin
		frame_nxt = frame_r;
		cnt_nxt   = cnt_r;
		sum_nxt   = sum_r;
		if (clear_i) begin
			cnt_nxt = '0;
			sum_nxt = '0;
		end else if (push_i && cnt_r < FRAME_LEN) begin
			frame_nxt = {frame_r[63:0], byte_i};
			cnt_nxt   = cnt_r + 4'h1;
			if (cnt_r < SUM_LEN) begin
				sum_nxt = sum_r + byte_i;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			frame_r <= '0;
			cnt_r   <= '0;
			sum_r   <= '0;
		end else begin
			frame_r <= frame_nxt;
			cnt_r   <= cnt_nxt;
			sum_r   <= sum_nxt;
		end
	end

	assign full_o   = (cnt_r == FRAME_LEN);
	assign count_o  = cnt_r;
	assign addr_o   = frame_r[FRM_ADDR_LSB +: 8];
	assign ins_o    = frame_r[FRM_INS_LSB +: 8];
	assign type_o   = frame_r[FRM_TYPE_LSB +: 8];
	assign motor_o  = frame_r[FRM_MOTOR_LSB +: 8];
	assign value_o  = frame_r[FRM_VALUE_LSB +: 32];
	assign sum_ok_o = (frame_r[FRM_SUM_LSB +: 8] == sum_r);
endmodule

/* host_model.sv */
// Purpose: host side model issuing classic wishbone cycles and command frames
// Assumes: slave answers every request with a one-cycle ack
// Notes:   released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module host_model import motion_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'hff;
		sel_o = 4'h0;
		dat_o = 32'hffff_ffff;
	end

	// ****************************************
	// one bus cycle, held until ack is sampled
	// ****************************************
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= we;
		adr_o <= adr;
		sel_o <= SEL_ALL;
		dat_o <= dat;
		@(posedge clk_i);
		while (ack_i !== 1'b1)
			@(posedge clk_i);
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~adr;
		dat_o <= ~dat;
	endtask

	// ****************************************
	// nine-byte frame; skew spoils the sum on purpose
	// ****************************************
	task automatic frame(input logic [7:0] addr, ins, typ, mot, input logic [31:0] val, input logic [7:0] skew);
		logic [7:0] b [9];
		b = '{addr, ins, typ, mot, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
		for (int i = 0; i < 8; i++)
			b[8] = b[8] + b[i];
		b[8] = b[8] + skew;
		for (int i = 0; i < 9; i++)
			xfer(1'b1, OFS_FRAME, {24'h0, b[i]});
	endtask
endmodule

/* test_motion_cmd_decoder.sv */
// Purpose: self-checking bench for the motion command decoder
// Assumes: host_model owns the register bus, one 100 MHz clock
// Notes:   memory starts unknown, so actual positions are written first
`timescale 1ns/1ps
module test_motion_cmd_decoder import motion_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        wb_cyc, wb_stb, wb_we, wb_ack_o, reply_o;
	logic [7:0]  wb_adr;
	logic [3:0]  wb_sel;
	logic [31:0] wb_wdat, wb_dat_o, v;
	logic [5:0]  axis_start_o, interp_o, pos_mode_o, dir_o, pm, dr, ip;
	logic [31:0] pt [6];
	logic [63:0] mon_e;
	logic [63:0] rd_q [$];
	logic [5:0]  st_q [$];
	int          bad_count = 0;
	int          checks = 0;

	always #5 clk_i = ~clk_i;

	host_model i_host_model (.clk_i(clk_i), .ack_i(wb_ack_o), .cyc_o(wb_cyc), .stb_o(wb_stb), .we_o(wb_we),
		.adr_o(wb_adr), .sel_o(wb_sel), .dat_o(wb_wdat));

	motion_cmd_decoder i_motion_cmd_decoder (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .axis_start_o(axis_start_o), .interp_o(interp_o), .pos_mode_o(pos_mode_o),
		.dir_o(dir_o), .reply_o(reply_o));

	// ****************************************
	// shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask

	task automatic close_out();
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] want, input logic [31:0] mask);
		rd_q.push_back({mask, want & mask});
		i_host_model.xfer(1'b0, adr, 32'h0);
	endtask

	task automatic mwr(input logic [8:0] a, input logic [31:0] d);
		i_host_model.xfer(1'b1, OFS_MADDR, {23'h0, a});
		i_host_model.xfer(1'b1, OFS_MDATA, d);
	endtask

	task automatic mrd(input logic [8:0] a, input logic [31:0] want);
		i_host_model.xfer(1'b1, OFS_MADDR, {23'h0, a});
		rd(OFS_MDATA, want, 32'hffff_ffff);
	endtask

	// instruction field only trusted on a successful reply
	task automatic cmd(input logic [7:0] ins, typ, mot, input logic [31:0] val, input logic [5:0] start,
		input logic [7:0] code, input logic [7:0] skew);
		st_q.push_back(start);
		i_host_model.frame(DEV_ADDR_RST, ins, typ, mot, val, skew);
		rd(OFS_REPLY, {8'h00, ins, 7'h00, 1'b1, code}, (code == ST_OK) ? 32'h00ff_01ff : 32'h0000_01ff);
	endtask

	task automatic stat();
		rd(OFS_STATUS, {2'b0, ip, 10'b0, dr, 2'b0, pm}, 32'h3f00_3f3f);
		check({14'h0, interp_o, dir_o, pos_mode_o}, {14'h0, ip, dr, pm});
	endtask

	// ****************************************
	// output watcher
	// ****************************************
	always @(posedge clk_i) begin
		if (!rst_i && reply_o === 1'b1) begin
			if (st_q.size() == 0)
				check(32'h1, 32'h0);
			else
				check({26'h0, axis_start_o}, {26'h0, st_q.pop_front()});
		end
		if (!rst_i && wb_ack_o === 1'b1 && wb_we === 1'b0) begin
			mon_e = rd_q.pop_front();
			check(wb_dat_o & mon_e[63:32], mon_e[31:0]);
		end
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		bad_count++;
		close_out();
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		void'($urandom(47409));
		pm = 6'h0;
		dr = 6'h0;
		ip = 6'h0;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		stat();
		rd(OFS_DEVADR, {24'h0, DEV_ADDR_RST}, 32'h0000_00ff);
		for (int a = 0; a < AXES; a++) begin
			v = $urandom;
			mwr(9'(a * 8 + 1), 32'h0);
			cmd(INS_SETP, 8'(PAR_TGT_SPEED), 8'(a), v, 6'h0, ST_OK, 8'h00);
			mrd(9'(a * 8 + 2), v);
		end
		cmd(INS_MOVE, ABSOLUTE_TARGET, 8'h00, 32'h8000_0000, 6'h01, ST_OK, 8'h00);
		mrd(9'h000, 32'h8000_0000);
		pm[0] = 1'b1;
		dr[0] = 1'b1;
		mwr(9'h009, 32'hffff_ff9c);
		v = 32'($urandom_range(4095, 200));
		cmd(INS_MOVE, RELATIVE_TARGET, 8'h01, v, 6'h02, ST_OK, 8'h00);
		mrd(9'h008, v - 32'd100);
		pm[1] = 1'b1;
		mwr(9'h011, 32'hffff_fff0);
		cmd(INS_MOVE, ABSOLUTE_TARGET, 8'h02, 32'h7fff_ffff, 6'h04, ST_OK, 8'h00);
		pm[2] = 1'b1;
		dr[2] = 1'b1;
		stat();
		for (int a = 0; a < AXES; a++) begin
			pt[a] = $urandom;
			mwr(9'(a * 8 + 1), 32'h0);
			mwr(STORED_POINT_TARGET_BASE + 9'(20 * 8 + a), pt[a]);
		end
		cmd(INS_MOVE, STORED_POINT_TARGET, 8'h04, MAX_STORED_POINT_TARGET, 6'h10, ST_OK, 8'h00);
		mrd(9'h020, pt[4]);
		cmd(INS_MOVE, STORED_POINT_TARGET, 8'hbf, MAX_STORED_POINT_TARGET, 6'h3f, ST_OK, 8'h00);
		for (int a = 0; a < AXES; a++) begin
			mrd(9'(a * 8), pt[a]);
			dr[a] = pt[a][31];
		end
		pm = 6'h3f;
		stat();
		for (int a = 1; a < AXES; a++)
			mwr(STORED_POINT_TARGET_BASE + 9'(3 * 8 + a), ~pt[a]);
		cmd(INS_MOVE, STORED_POINT_TARGET, 8'h7e, 32'h3, 6'h0e, ST_OK, 8'h00);
		for (int a = 1; a < AXES; a++) begin
			mrd(9'(a * 8), (a < 4) ? ~pt[a] : pt[a]);
			if (a < 4)
				dr[a] = ~pt[a][31];
		end
		ip = 6'h0e;
		stat();
		cmd(INS_STOP, 8'h00, 8'h02, 32'h0, 6'h00, ST_OK, 8'h00);
		mrd(9'h012, 32'h0);
		pm[2] = 1'b0;
		ip[2] = 1'b0;
		stat();
		// refused frames leave the axes alone
		cmd(INS_STOP, 8'h00, 8'h00, 32'h0, 6'h00, ST_BAD_SUM, 8'h01);
		cmd(8'h0a, 8'h00, 8'h00, 32'h0, 6'h00, ST_BAD_CMD, 8'h00);
		cmd(INS_MOVE, STORED_POINT_TARGET, 8'h00, 32'h15, 6'h00, ST_BAD_ARG, 8'h00);
		cmd(INS_MOVE, 8'h03, 8'h00, 32'h0, 6'h00, ST_BAD_ARG, 8'h00);
		stat();
		i_host_model.xfer(1'b1, OFS_REPLY, 32'h0);
		i_host_model.frame(8'h02, INS_STOP, 8'h00, 8'h00, 32'h0, 8'h00);
		rd(OFS_REPLY, 32'h0, 32'h0000_0100);
		stat();
		repeat (5) @(posedge clk_i);
		check(32'(st_q.size() + rd_q.size()), 32'h0);
		close_out();
	end
endmodule
